// ==== common/spv_pkg.sv ====
// package: constants and carrier types for the port-info vital-data page responder
`default_nettype none
package spv_pkg;
  localparam logic [7:0] SPV_PAGE_LU          = 8'h90;
  localparam logic [7:0] SPV_PAGE_PORT        = 8'h91;
  localparam logic [2:0] SPV_QUALIFIER        = 3'h0;
  localparam logic [4:0] SPV_DEV_TYPE         = 5'h00;
  localparam logic [15:0] SPV_PAGE_LEN        = 16'h0018;
  localparam logic [15:0] SPV_DESC_LEN        = 16'h0004;
  localparam logic [3:0] SPV_PROTO_SAS        = 4'h6;
  localparam logic [15:0] SPV_REL_PORT_A      = 16'h0001;
  localparam logic [15:0] SPV_REL_PORT_B      = 16'h0002;
  localparam logic [7:0] SPV_PHY_ID_A         = 8'h00;
  localparam logic [7:0] SPV_PHY_ID_B         = 8'h01;
  localparam logic       SPV_RETRY_CTRL_SUP   = 1'b0;
  localparam logic       SPV_PWR_DIS_SUP      = 1'b1;
  localparam logic       SPV_PERSIST_CAP      = 1'b0;
  // page layout: header 4 bytes, two 12-byte descriptors
  localparam logic [4:0] SPV_HDR_BYTES        = 5'h04;
  localparam logic [4:0] SPV_DESC_BYTES       = 5'h0C;
  localparam logic [4:0] SPV_LAST_BYTE        = 5'h1B;
  localparam logic [7:0] SPV_ZERO             = 8'h00;

  typedef struct packed {
    logic       valid;
    logic [7:0] page_code;
  } spv_req_t;

  typedef struct packed {
    logic       valid;
    logic       last;
    logic [4:0] index;
    logic [7:0] data;
  } spv_byte_t;
endpackage : spv_pkg
`default_nettype wire

// ==== src/spv_desc_rom.sv ====
// per-port descriptor byte generator for both page kinds
`default_nettype none
module spv_desc_rom (
  input  wire logic       port_sel,
  input  wire logic       port_page,
  input  wire logic [3:0] offset,
  output var  logic [7:0] data
);
  import spv_pkg::*;

  logic [15:0] rel_port;
  logic [7:0]  phy_id;

  always_comb begin
    rel_port = port_sel ? SPV_REL_PORT_B : SPV_REL_PORT_A;
    phy_id   = port_sel ? SPV_PHY_ID_B : SPV_PHY_ID_A;
    data     = SPV_ZERO;
    case (offset)
      4'h0: data = rel_port[15:8];
      4'h1: data = rel_port[7:0];
      4'h2: data = {4'h0, SPV_PROTO_SAS};
      4'h3: data = port_page ? {7'h00, SPV_PWR_DIS_SUP} : SPV_ZERO;
      4'h6: data = SPV_DESC_LEN[15:8];
      4'h7: data = SPV_DESC_LEN[7:0];
      4'h8: data = port_page ? SPV_ZERO : {7'h00, SPV_RETRY_CTRL_SUP};
      4'h9: data = port_page ? phy_id : SPV_ZERO;
      4'hB: data = port_page ? {7'h00, SPV_PERSIST_CAP} : SPV_ZERO;
      default: data = SPV_ZERO;
    endcase
  end
endmodule // spv_desc_rom
`default_nettype wire

// ==== src/spv_responder.sv ====
// response byte streamer for the logical-unit and port information pages
`default_nettype none
module spv_responder (
  input  wire logic              clk,
  input  wire logic              rst_n,
  input  wire spv_pkg::spv_req_t req,
  output logic                   req_ready,
  output logic                   req_reject,
  input  wire logic              out_ready,
  output spv_pkg::spv_byte_t     out_byte
);
  import spv_pkg::*;

  typedef enum logic [0:0] {
    SPV_IDLE = 1'b0,
    SPV_SEND = 1'b1
  } spv_state_t;

  ////////////////////////////////////////////////////////////////////////
  // state
  spv_state_t state_q, state_d;
  logic [4:0] idx_q, idx_d;
  logic [7:0] page_q, page_d;
  logic       reject_q, reject_d;
  spv_byte_t  out_q, out_d;

  logic       port_page;
  logic       port_sel;
  logic [4:0] rel;
  logic [3:0] desc_off;
  logic [7:0] desc_data;
  logic [7:0] hdr_data;
  logic       supported;
  logic       advance;

  function automatic logic page_ok(input logic [7:0] code);
    page_ok = (code == SPV_PAGE_LU) || (code == SPV_PAGE_PORT);
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // byte selection
  always_comb begin
    port_page = (page_q == SPV_PAGE_PORT);
    rel       = idx_q - SPV_HDR_BYTES;
    port_sel  = (rel >= SPV_DESC_BYTES);
    desc_off  = port_sel ? 4'(rel - SPV_DESC_BYTES) : rel[3:0];
    case (idx_q[1:0])
      2'h0: hdr_data = {SPV_QUALIFIER, SPV_DEV_TYPE};
      2'h1: hdr_data = page_q;
      2'h2: hdr_data = SPV_PAGE_LEN[15:8];
      default: hdr_data = SPV_PAGE_LEN[7:0];
    endcase
  end

  spv_desc_rom u_desc (
    .port_sel  (port_sel),
    .port_page (port_page),
    .offset    (desc_off),
    .data      (desc_data)
  );

  ////////////////////////////////////////////////////////////////////////
  // sequencer; one page at a time, later requests wait on req_ready
  always_comb begin
    supported = page_ok(req.page_code);
    advance   = !out_q.valid || out_ready;
    state_d   = state_q;
    idx_d     = idx_q;
    page_d    = page_q;
    reject_d  = 1'b0;
    out_d     = out_q;
    if (out_q.valid && out_ready) begin
      out_d.valid = 1'b0;
      out_d.last  = 1'b0;
    end
    case (state_q)
      SPV_IDLE: begin
        if (req.valid) begin
          if (supported) begin
            page_d  = req.page_code;
            idx_d   = 5'h00;
            state_d = SPV_SEND;
          end else begin
            // other pages belong to another responder
            reject_d = 1'b1;
          end
        end
      end
      SPV_SEND: begin
        if (advance) begin
          out_d.valid = 1'b1;
          out_d.index = idx_q;
          out_d.data  = (idx_q < SPV_HDR_BYTES) ? hdr_data : desc_data;
          out_d.last  = (idx_q == SPV_LAST_BYTE);
          idx_d       = idx_q + 5'h01;
          if (idx_q == SPV_LAST_BYTE) begin
            state_d = SPV_IDLE;
          end
        end
      end
      default: state_d = SPV_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q  <= SPV_IDLE;
      idx_q    <= 5'h00;
      page_q   <= 8'h00;
      reject_q <= 1'b0;
      out_q    <= '0;
    end else begin
      state_q  <= state_d;
      idx_q    <= idx_d;
      page_q   <= page_d;
      reject_q <= reject_d;
      out_q    <= out_d;
    end
  end

  assign req_ready  = (state_q == SPV_IDLE);
  assign req_reject = reject_q;
  assign out_byte   = out_q;
endmodule // spv_responder
`default_nettype wire

// ==== tb/spv_properties.sv ====
// checker: port properties of the page responder
`default_nettype none
module spv_properties (
  input wire logic               clk,
  input wire logic               rst_n,
  input wire spv_pkg::spv_req_t  req,
  input wire logic               req_ready,
  input wire logic               req_reject,
  input wire logic               out_ready,
  input wire spv_pkg::spv_byte_t out_byte
);
  wire logic       v  = out_byte.valid;
  wire logic [4:0] ix = out_byte.index;
  wire logic [7:0] dt = out_byte.data;
  wire logic       ok = req.page_code inside {8'h90, 8'h91};
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence s_take; req.valid && req_ready; endsequence
  AST_REJ: assert property (s_take ##0 !ok |-> ##[1:2] req_reject) else $error("rej");
  AST_GO: assert property (s_take ##0 ok |-> ##[1:2] v && ix == 5'h00) else $error("go");
  AST_B0: assert property (v && ix == 5'h00 |-> dt == 8'h00) else $error("b0");
  AST_LEN: assert property (v && ix == 5'h03 |-> dt == 8'h18) else $error("len");
  AST_PID: assert property (v && ix inside {5'h06, 5'h12} |-> dt == 8'h06) else $error("p");
  AST_LAST: assert property (v |-> out_byte.last == (ix == 5'h1B)) else $error("last");
  AST_HOLD: assert property (v && !out_ready |=> $stable(out_byte)) else $error("hold");
  AST_STEP: assert property (v && out_ready && !out_byte.last |=> ix == $past(ix) + 5'h01)
    else $error("step");
endmodule // spv_properties
bind spv_responder spv_properties spv_properties_i (.*);
`default_nettype wire

// ==== tb/spv_sink.sv ====
// sink model: takes a byte every second cycle
`default_nettype none
module spv_sink (
  input wire logic clk,
  output logic     out_ready
);
  timeunit 1ns / 1ns;
  // an alternating stall keeps the hold path busy on every page
  always @(negedge clk) out_ready <= (out_ready !== 1'b1);
endmodule // spv_sink
`default_nettype wire

// ==== tb/tb.sv ====
// testbench: both pages back to back, then a refused page code
`default_nettype none
module tb;
  timeunit 1ns / 1ns;
  logic clk = 1'b0, rst_n = 1'b0, req_ready, req_reject, out_ready;
  spv_pkg::spv_req_t  req = '0;
  spv_pkg::spv_byte_t out_byte;
  int errors = 0, n_compared = 0, n_rej = 0;
  localparam logic [223:0] e90 = 224'h00900018_000106000000000400000000_000206000000000400000000;
  localparam logic [223:0] e91 = 224'h00910018_000106010000000400000000_000206010000000400010000;
  initial forever #20 clk = !clk;
  always @(negedge clk) n_rej += int'(req_reject);
  spv_responder spv_responder_i (.*);
  spv_sink spv_sink_i (.*);
  task automatic chk(logic [7:0] g, logic [7:0] e);
    n_compared++;
    errors += int'(g !== e);
    if (g !== e) $display("[ERR] %0t got %h want %h", $time, g, e);
  endtask
  task automatic ask(logic [7:0] pg);
    @(negedge clk) req = {1'b1, pg};
    for (int t = 0; t < 40 && req_ready !== 1'b1; t++) @(negedge clk);
    @(negedge clk) req = '0;
  endtask
  task automatic page(logic [7:0] pg);
    int n = 0;
    ask(pg);
    for (int t = 0; t < 99 && n < 28; t++) begin
      @(negedge clk) #5;
      if (out_byte.valid === 1'b1 && out_ready === 1'b1) begin
        chk({out_byte.last, 2'h0, out_byte.index}, {n == 27, 2'h0, 5'(n)});
        chk(out_byte.data, 8'((pg == 8'h91 ? e91 : e90) >> (216 - 8 * n)));
        n++;
      end
    end
    chk(8'(n), 8'h1C);
  endtask
  task automatic t_bad();
    int r = n_rej;
    ask(8'h92);
    repeat (3) @(negedge clk);
    chk(8'(n_rej - r), 8'h01);
    chk({6'h00, out_byte.valid, req_ready}, 8'h01);
  endtask
  task automatic print_verdict();
    $display("compared %0d errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial begin
    #120 rst_n = 1'b1;
    page(8'h90);
    page(8'h91);
    t_bad();
    print_verdict();
  end
  initial begin
    #20000 errors++;
    print_verdict();
  end
endmodule // tb
`default_nettype wire
